// ---- src/lorie_pkg.sv ----
// Constants and types for the OR-literal-into-accumulator executor
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package lorie_pkg;

  localparam int unsigned DATA_W      = 8;
  localparam int unsigned OPCODE_W    = 16;
  localparam int unsigned STATUS_W    = 5;
  localparam logic [7:0]  OP_OR_LIT   = 8'h09;
  localparam int unsigned OP_HI_MSB   = 15;
  localparam int unsigned OP_HI_LSB   = 8;
  localparam int unsigned LIT_MSB     = 7;
  localparam int unsigned LIT_LSB     = 0;
  localparam int unsigned SIGN_BIT    = 7;
  // Status layout: C=0, DC=1, Z=2, OV=3, N=4
  localparam int unsigned FLAG_Z      = 2;
  localparam int unsigned FLAG_N      = 4;
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [4:0]  STATUS_RESET = 5'h00;

  typedef enum logic [1:0] {
    LORIE_Q1,
    LORIE_Q2,
    LORIE_Q3,
    LORIE_Q4
  } lorie_phase_t;

  typedef struct packed {
    lorie_phase_t phase;
    logic         hit;
    logic [7:0]   lit;
    logic [7:0]   result;
    logic [7:0]   acc;
    logic [4:0]   status;
    logic         done;
  } lorie_state_t;

endpackage : lorie_pkg

// ---- src/lorie_exec.sv ----
// Executor for the OR-literal-into-accumulator instruction
`timescale 1ns/1ps
`default_nettype none

module lorie_exec (
  input  wire logic                           core_clk_i,    // Core clock
  input  wire logic                           rstn_i,        // Reset, low
  input  wire logic                           q_start_i,     // Q1 begins
  input  wire logic [lorie_pkg::OPCODE_W-1:0] opcode_i,      // Opcode word
  input  wire logic [lorie_pkg::DATA_W-1:0]   acc_i,         // Acc load
  input  wire logic                           acc_load_i,    // Load acc
  input  wire logic [lorie_pkg::STATUS_W-1:0] status_i,      // Status load
  input  wire logic                           status_load_i, // Load status
  output logic      [lorie_pkg::DATA_W-1:0]   acc_o,         // Accumulator
  output logic      [lorie_pkg::STATUS_W-1:0] status_o,      // Status flags
  output logic                                hit_o,         // Opcode match
  output logic                                done_o,        // Q4 write
  output logic                                mem_we_o       // Memory write
);
  import lorie_pkg::*;

  // -------------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------------
  // Slices and the state struct take their widths from the package; a
  // mismatch there would silently mis-slice the opcode, so refuse it.
  if (OPCODE_W != 2 * DATA_W) begin : g_bad_opcode_w
    $error("lorie_exec: opcode word must be two data bytes wide");
  end

  if (OP_HI_MSB != OPCODE_W - 1) begin : g_bad_hi_msb
    $error("lorie_exec: opcode byte must end at the top bit");
  end

  if (OP_HI_LSB != DATA_W) begin : g_bad_hi_lsb
    $error("lorie_exec: opcode byte must start above the literal");
  end

  if (LIT_MSB != DATA_W - 1) begin : g_bad_lit_msb
    $error("lorie_exec: literal must be one data byte wide");
  end

  if (LIT_LSB != 0) begin : g_bad_lit_lsb
    $error("lorie_exec: literal must sit in the low byte");
  end

  if ($bits(OP_OR_LIT) != DATA_W) begin : g_bad_op_code
    $error("lorie_exec: opcode constant must be one data byte wide");
  end

  if (SIGN_BIT != DATA_W - 1) begin : g_bad_sign
    $error("lorie_exec: sign bit must be the top data bit");
  end

  if (FLAG_N >= STATUS_W || FLAG_Z >= STATUS_W) begin : g_bad_flag_pos
    $error("lorie_exec: flag position outside the status word");
  end

  if (FLAG_N == FLAG_Z) begin : g_bad_flag_same
    $error("lorie_exec: negative and zero flags must differ");
  end

  if ($bits(ACC_RESET) != DATA_W) begin : g_bad_acc_reset
    $error("lorie_exec: accumulator reset value has the wrong width");
  end

  if ($bits(STATUS_RESET) != STATUS_W) begin : g_bad_status_reset
    $error("lorie_exec: status reset value has the wrong width");
  end

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  lorie_state_t st;      // Registered state
  lorie_state_t next_st; // Next state

  // Reset image: idle in Q1, nothing pending, accumulator and status clear
  localparam lorie_state_t ST_RESET = '{
    phase:  LORIE_Q1,
    hit:    1'b0,
    lit:    '0,
    result: '0,
    acc:    ACC_RESET,
    status: STATUS_RESET,
    done:   1'b0
  };

  // -------------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------------
  logic [DATA_W-1:0] op_high;    // Opcode byte of the fetched word
  logic [DATA_W-1:0] op_literal; // Immediate byte of the fetched word
  logic              op_match;   // Fetched word is this instruction
  logic              take_start; // Start pulse accepted this edge

  assign op_high    = opcode_i[OP_HI_MSB:OP_HI_LSB];
  assign op_literal = opcode_i[LIT_MSB:LIT_LSB];
  assign op_match   = (op_high == OP_OR_LIT);

  // A start pulse outside Q1 belongs to no instruction and is dropped
  assign take_start = q_start_i && (st.phase == LORIE_Q1);

  // -------------------------------------------------------------------------
  // Operate
  // -------------------------------------------------------------------------
  logic [DATA_W-1:0] or_bits;     // Accumulator ORed with the literal
  logic              result_neg;  // Sign of the stored result
  logic              result_zero; // Stored result is all zeros

  // One OR gate per data bit, fed by the held accumulator and literal
  for (genvar b = 0; b < DATA_W; b = b + 1) begin : g_or_bit
    assign or_bits[b] = st.acc[b] | st.lit[b];
  end

  // Flags come from the stored result so the Q4 edge sees a settled value
  assign result_neg  = st.result[SIGN_BIT];
  assign result_zero = ~|st.result;

  // -------------------------------------------------------------------------
  // Load gating
  // -------------------------------------------------------------------------
  logic in_write;    // State is Q4, the write-back edge
  logic acc_take;    // Accumulator load lands this edge
  logic status_take; // Status load lands this edge

  // Loads are dropped on the Q4 edge so the write never races a load;
  // software must not load in Q4 and expect the value to stick.
  assign in_write    = (st.phase == LORIE_Q4);
  assign acc_take    = acc_load_i && !in_write;
  assign status_take = status_load_i && !in_write;

  // -------------------------------------------------------------------------
  // Write-back values
  // -------------------------------------------------------------------------
  logic [STATUS_W-1:0] flags_after; // Status image after the Q4 update
  logic                write_back;  // Q4 edge of a matching instruction

  // Each status bit takes N, Z or its own held value; carry, digit carry
  // and overflow pass through because this instruction leaves them alone.
  for (genvar k = 0; k < STATUS_W; k = k + 1) begin : g_flag_bit
    if (k == FLAG_N) begin : g_neg
      assign flags_after[k] = result_neg;
    end else if (k == FLAG_Z) begin : g_zero
      assign flags_after[k] = result_zero;
    end else begin : g_keep
      assign flags_after[k] = st.status[k];
    end
  end

  assign write_back = in_write && st.hit;

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    unique case (st.phase)
      LORIE_Q1: begin
        // Literal is latched on the start edge, so the fetch side may
        // move on to its next word straight away.
        if (take_start) begin
          next_st.hit   = op_match;
          next_st.lit   = op_literal;
          next_st.phase = LORIE_Q2;
        end
      end
      LORIE_Q2: begin
        next_st.phase = LORIE_Q3;
      end
      LORIE_Q3: begin
        // Operand is the accumulator as held in Q3; a load landing on
        // this edge is overwritten by the Q4 write of a match.
        next_st.result = or_bits;
        next_st.phase  = LORIE_Q4;
      end
      LORIE_Q4: begin
        if (write_back) begin
          next_st.acc    = st.result;
          next_st.status = flags_after;
          next_st.done   = 1'b1;
        end
        next_st.hit   = 1'b0;
        next_st.phase = LORIE_Q1;
      end
    endcase
    if (acc_take) begin
      next_st.acc = acc_i;
    end
    if (status_take) begin
      next_st.status = status_i;
    end
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  // -------------------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------------------
  assign acc_o    = st.acc;
  assign status_o = st.status;
  assign hit_o    = st.hit;
  assign done_o   = st.done;

  // No data-memory destination exists for this instruction
  assign mem_we_o = 1'b0;

endmodule : lorie_exec

`default_nettype wire

// ---- testbench/lorie_chk.sv ----
// Assertions on the OR-literal executor ports
`timescale 1ns/1ps
`default_nettype none
module lorie_chk (
  input wire logic        core_clk_i, // Clock
  input wire logic        rstn_i,     // Reset
  input wire logic        q_start_i,  // Q1
  input wire logic [15:0] opcode_i,   // Opcode
  input wire logic [7:0]  acc_o,      // Acc
  input wire logic [4:0]  status_o,   // Flags
  input wire logic        hit_o,      // Match
  input wire logic        done_o,     // Write
  input wire logic        mem_we_o    // Mem
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  chk_or_value: assert property (done_o |->
    acc_o == ($past(acc_o, 2) | $past(opcode_i[7:0], 4)))
    else $error("bad or");
  chk_mem_idle: assert property (!mem_we_o) else $error("mem write");
  chk_nz_flags: assert property (done_o |-> status_o[4] == acc_o[7]
    && status_o[2] == (acc_o == 8'h00)) else $error("bad n/z");
  chk_flags_kept: assert property (done_o |->
    $stable({status_o[3], status_o[1:0]})) else $error("flag moved");
  chk_decode_hit: assert property ($rose(hit_o) |->
    $past(opcode_i[15:8]) == 8'h09) else $error("bad decode");
  chk_miss_quiet: assert property (q_start_i && !hit_o &&
    opcode_i[15:8] != 8'h09 |-> ##4 !done_o) else $error("miss wrote");
  chk_four_phases: assert property ($rose(hit_o) |->
    hit_o[*3] ##1 (done_o && !hit_o)) else $error("bad phases");
  cover property (done_o && status_o[4]);
  cover property (done_o && status_o[2]);
  cover property (q_start_i && opcode_i[15:8] != 8'h09);
endmodule : lorie_chk
`default_nettype wire

// ---- testbench/lorie_fetch.sv ----
// Fetch-unit model handing opcode words to the executor
`timescale 1ns/1ps
`default_nettype none
module lorie_fetch (
  input  wire logic        clk_i,     // Clock
  output var  logic        q_start_o, // Q1
  output var  logic [15:0] opcode_o   // Opcode
);
  initial q_start_o = 1'b0;
  initial opcode_o = 16'h0000;
  // Word is inverted after Q1 so a late sample shows up; returns as soon
  // as the start pulse is over, the caller paces the later phases
  task automatic issue(input logic [15:0] w);
    @(negedge clk_i) {q_start_o, opcode_o} = {1'b1, w};
    @(negedge clk_i) {q_start_o, opcode_o} = {1'b0, ~w};
  endtask : issue
endmodule : lorie_fetch
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the OR-literal executor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
  logic core_clk_i = 1'b0, rstn_i = 1'b0, acc_load_i = 1'b0;
  logic status_load_i = 1'b0, q_start_i, hit_o, done_o, mem_we_o;
  logic [7:0] acc_i = 8'h00, acc_o;
  logic [4:0] status_i = 5'h00, status_o;
  logic [15:0] opcode_i;
  int mismatches = 0, num_checks = 0;
  lorie_fetch i_fetch (.clk_i(core_clk_i), .q_start_o(q_start_i),
    .opcode_o(opcode_i));
  lorie_exec i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .q_start_i(q_start_i), .opcode_i(opcode_i), .acc_i(acc_i),
    .acc_load_i(acc_load_i), .status_i(status_i),
    .status_load_i(status_load_i), .acc_o(acc_o), .status_o(status_o),
    .hit_o(hit_o), .done_o(done_o), .mem_we_o(mem_we_o));
  initial forever #5 core_clk_i = ~core_clk_i;
  task automatic run(input logic [7:0] a, input logic [4:0] s,
    input logic [15:0] op, input logic hit);
    @(negedge core_clk_i) {acc_i, status_i, acc_load_i, status_load_i} =
      {a, s, 2'b11};
    @(negedge core_clk_i) {acc_load_i, status_load_i} = 2'b00;
    i_fetch.issue(op);
    `CHK(hit_o, hit)
    repeat (2) @(negedge core_clk_i);
    `CHK(done_o, 1'b0)
    `CHK(acc_o, a)
    @(negedge core_clk_i);
  endtask : run
  task automatic t_or;
    run(8'h9a, 5'h0b, 16'h0935, 1'b1);
    `CHK(acc_o, 8'hbf)
    `CHK(status_o, 5'h1b)
    `CHK(done_o, 1'b1)
    `CHK(mem_we_o, 1'b0)
    $display("t_or ended");
  endtask : t_or
  task automatic t_miss;
    run(8'h00, 5'h1f, 16'h0855, 1'b0);
    `CHK(acc_o, 8'h00)
    `CHK(status_o, 5'h1f)
    `CHK(done_o, 1'b0)
    run(8'h00, 5'h1f, 16'h0900, 1'b1);
    `CHK(status_o, 5'h0f)
    `CHK(acc_o, 8'h00)
    $display("t_miss ended");
  endtask : t_miss
  // Second start lands in Q3 of the first and must be ignored
  task automatic t_busy;
    @(negedge core_clk_i) {acc_i, acc_load_i} = {8'h40, 1'b1};
    @(negedge core_clk_i) acc_load_i = 1'b0;
    i_fetch.issue(16'h0902);
    i_fetch.issue(16'h0981);
    `CHK(done_o, 1'b0)
    @(negedge core_clk_i);
    `CHK(done_o, 1'b1)
    `CHK(acc_o, 8'h42)
    `CHK(status_o, 5'h0b)
    repeat (4) @(negedge core_clk_i);
    `CHK(acc_o, 8'h42)
    `CHK(done_o, 1'b0)
    $display("t_busy ended");
  endtask : t_busy
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(negedge core_clk_i);
    rstn_i = 1'b1;
    t_or;
    t_miss;
    t_busy;
    conclude;
  end
  initial begin
    // Scripted run is about 36 cycles; allow over five times that
    #2000 mismatches++;
    conclude;
  end
endmodule : tb_top
bind lorie_exec lorie_chk i_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .q_start_i(q_start_i), .opcode_i(opcode_i), .acc_o(acc_o),
  .status_o(status_o), .hit_o(hit_o), .done_o(done_o),
  .mem_we_o(mem_we_o));
`default_nettype wire
